// File: legacy_mode_address_formation.sv
// Purpose: legacy 16-bit compatibility mode address formation and mode control
// Assumes: pipeline signals are on the core clock; paging lives outside
// Notes: registers over classic wishbone, one-cycle ack, one level irq
module legacy_mode_address_formation
    import legacy_mode_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CLK_EN,
    // wishbone slave
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_WB_WE,
    input wire logic [7:0] I_WB_ADR,
    input wire logic [3:0] I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    output logic [31:0] O_WB_DAT,
    output logic O_WB_ACK,
    output logic O_IRQ,
    // segment register load
    input wire logic I_SEG_LOAD,
    input wire logic [SEG_IDX_W-1:0] I_SEG_IDX,
    input wire logic [15:0] I_SEG_SEL,
    input wire logic [31:0] I_SEG_DESC_BASE,
    output logic O_DESC_FETCH,
    // memory access
    input wire logic I_ACC_REQ,
    input wire logic [SEG_IDX_W-1:0] I_ACC_SEG,
    input wire logic [31:0] I_ACC_EA,
    input wire logic I_ACC_OPSIZE_PFX,
    output logic O_LIN_REQ,
    output logic [31:0] O_LIN_ADDR,
    output logic O_LIN_USER,
    output logic O_LIN_OPSIZE32,
    output logic O_FAULT,
    output logic [7:0] O_FAULT_VEC,
    output logic O_FAULT_ERRCODE,
    // paging permission check
    input wire logic I_PG_CHECK,
    input wire logic I_PG_USER_OK,
    output logic O_PG_DENY,
    // privilege of protected-mode code
    input wire logic [1:0] I_CS_RPL,
    output logic [1:0] O_PRIV_LEVEL,
    output logic O_DEC_LEGACY,
    // mode transitions
    input wire logic I_INT_ENTRY,
    input wire logic I_INT_TO_PL0,
    output logic O_PUSH_VALID,
    output logic [31:0] O_PUSH_DATA,
    input wire logic I_INT_RETURN,
    input wire logic [31:0] I_INT_RETURN_FLAGS,
    input wire logic I_TASK_LOAD,
    input wire logic I_TASK_FMT32,
    input wire logic [31:0] I_TASK_FLAGS
);
    logic [31:0] flags_reg;                  // processor flags word
    logic [EV_W-1:0] status_reg;             // sticky events
    logic [EV_W-1:0] mask_reg;               // interrupt enables
    logic [31:0] fault_ea_reg;               // last faulting offset
    logic [31:0] ctrl_reg;                   // fault vector selection
    logic [31:0] seg_base_reg [SEG_COUNT];   // cached segment bases
    logic [1:0] code_priv_reg;               // protected-mode privilege
    entry_state_type ent_state_reg;          // interrupt entry sequencing
    logic [EV_W-1:0] ev_set;                 // events raised this cycle
    logic virtual_machine_flag;              // current mode
    logic [1:0] current_privilege_level;     // effective privilege
    logic wb_req;                            // new bus cycle
    logic wb_wr;                             // write strobe
    logic [31:0] wb_mask;                    // byte-lane mask
    logic [31:0] wb_rdata;                   // read mux
    logic [BASE_W-1:0] acc_base;             // legacy base of access segment
    logic [LIN_W-1:0] lin_sum;               // legacy sum with carry
    logic range_fault;                       // legacy offset out of range
    logic legacy_next;                       // mode after this cycle's events
    logic [31:0] flags_next;

    // mode and privilege decode
    assign virtual_machine_flag = flags_reg[VMF_BIT];
    // legacy code always runs least privileged regardless of the code selector
    assign current_privilege_level = virtual_machine_flag ? PRIV_USER : code_priv_reg;

    // bus strobes; the master holds the cycle until ack, so a pending ack blocks a second hit
    assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    assign wb_wr = wb_req && I_WB_WE;
    assign wb_mask = {{8{I_WB_SEL[3]}}, {8{I_WB_SEL[2]}}, {8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};

    // address formation: legacy base is the cached selector shifted
    assign acc_base = seg_base_reg[I_ACC_SEG][BASE_W-1:0];
    // carry kept into bit 20, no wrap at the first megabyte
    assign lin_sum = {1'b0, acc_base} + {{(LIN_W-OFS_W){1'b0}}, I_ACC_EA[OFS_W-1:0]};
    // the only legacy check is the offset range, even with a 32-bit address override
    assign range_fault = virtual_machine_flag && (I_ACC_EA > EA_MAX);

    // event collection
    always_comb begin
        ev_set = '0;
        ev_set[EV_FAULT] = I_ACC_REQ && range_fault;
        ev_set[EV_PAGE_DENY] = I_PG_CHECK && (current_privilege_level == PRIV_USER) && !I_PG_USER_OK;
        ev_set[EV_LEGACY_ENTER] = !virtual_machine_flag && legacy_next;
        ev_set[EV_LEGACY_EXIT] = virtual_machine_flag && !legacy_next;
    end

    // next flags word: hardware transitions beat a software write in the same cycle
    always_comb begin
        flags_next = flags_reg;
        if (wb_wr && (I_WB_ADR == ADR_FLAGS)) begin
            flags_next = (flags_reg & ~wb_mask) | (I_WB_DAT & wb_mask);
        end
        if (ent_state_reg == ENT_CLEAR) begin
            // the image was pushed last cycle, only now leave legacy mode
            flags_next[VMF_BIT] = 1'b0;
        end else if (I_TASK_LOAD) begin
            // only the 32-bit task image carries the mode flag
            flags_next = I_TASK_FMT32 ? I_TASK_FLAGS : (flags_reg & ~(32'h1 << VMF_BIT));
        end else if (I_INT_RETURN) begin
            flags_next = I_INT_RETURN_FLAGS;
            if (current_privilege_level != PRIV_KERNEL) begin
                flags_next[VMF_BIT] = flags_reg[VMF_BIT];
            end
        end
        flags_next = flags_next | FLAGS_FIXED_ONE;
        legacy_next = flags_next[VMF_BIT];
    end

    // flags word register
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            flags_reg <= FLAGS_RESET;
        end else if (I_CLK_EN) begin
            flags_reg <= flags_next;
        end
    end

    // interrupt entry: push the whole word first, clear the flag a cycle later
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            ent_state_reg <= ENT_IDLE;
            O_PUSH_VALID <= 1'b0;
            O_PUSH_DATA <= '0;
        end else if (I_CLK_EN) begin
            O_PUSH_VALID <= 1'b0;
            case (ent_state_reg)
                ENT_IDLE: begin
                    if (I_INT_ENTRY) begin
                        O_PUSH_VALID <= 1'b1;
                        O_PUSH_DATA <= flags_reg;
                        // a non-kernel handler keeps the mode; the caller raises its own fault
                        if (virtual_machine_flag && I_INT_TO_PL0) begin
                            ent_state_reg <= ENT_CLEAR;
                        end
                    end
                end
                ENT_CLEAR: begin
                    ent_state_reg <= ENT_IDLE;
                end
                default: begin
                    ent_state_reg <= ENT_IDLE;
                end
            endcase
        end
    end

    // protected-mode privilege tracks the code selector
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            code_priv_reg <= PRIV_KERNEL;
            O_PRIV_LEVEL <= PRIV_KERNEL;
            O_DEC_LEGACY <= 1'b0;
        end else if (I_CLK_EN) begin
            code_priv_reg <= I_CS_RPL;
            O_PRIV_LEVEL <= current_privilege_level;
            // decode uses this to pick the sensitive and unsupported opcode sets
            O_DEC_LEGACY <= virtual_machine_flag;
        end
    end

    // segment loads: legacy mode forms the base itself, protected mode takes the descriptor
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            for (int i = 0; i < SEG_COUNT; i++) begin
                seg_base_reg[i] <= '0;
            end
            O_DESC_FETCH <= 1'b0;
        end else if (I_CLK_EN) begin
            O_DESC_FETCH <= I_SEG_LOAD && !virtual_machine_flag;
            if (I_SEG_LOAD && (int'(I_SEG_IDX) < SEG_COUNT)) begin
                if (virtual_machine_flag) begin
                    seg_base_reg[I_SEG_IDX] <= {{(32-BASE_W){1'b0}}, I_SEG_SEL, {SEL_SHIFT{1'b0}}};
                end else begin
                    seg_base_reg[I_SEG_IDX] <= I_SEG_DESC_BASE;
                end
            end
        end
    end

    // access path: one cycle from request to linear request or fault
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_LIN_REQ <= 1'b0;
            O_LIN_ADDR <= '0;
            O_LIN_USER <= 1'b0;
            O_LIN_OPSIZE32 <= 1'b0;
            O_FAULT <= 1'b0;
            O_FAULT_VEC <= VEC_GP;
            O_FAULT_ERRCODE <= 1'b0;
            fault_ea_reg <= '0;
        end else if (I_CLK_EN) begin
            O_LIN_REQ <= I_ACC_REQ && !range_fault;
            O_FAULT <= I_ACC_REQ && range_fault;
            O_FAULT_ERRCODE <= 1'b0;
            if (I_ACC_REQ && range_fault) begin
                O_FAULT_VEC <= ctrl_reg[CTRL_VEC12] ? VEC_STACK : VEC_GP;
                fault_ea_reg <= I_ACC_EA;
            end else if (I_ACC_REQ) begin
                // all six segments, the extra two included, resolve the same way
                if (virtual_machine_flag) begin
                    O_LIN_ADDR <= {{(32-LIN_W){1'b0}}, lin_sum};
                end else begin
                    O_LIN_ADDR <= seg_base_reg[I_ACC_SEG] + I_ACC_EA;
                end
                O_LIN_USER <= current_privilege_level == PRIV_USER;
                O_LIN_OPSIZE32 <= I_ACC_OPSIZE_PFX;
            end
        end
    end

    // paging permission answer, one cycle after the check
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_PG_DENY <= 1'b0;
        end else if (I_CLK_EN) begin
            O_PG_DENY <= ev_set[EV_PAGE_DENY];
        end
    end

    // control registers written by software
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            mask_reg <= '0;
            ctrl_reg <= '0;
        end else if (I_CLK_EN && wb_wr) begin
            if (I_WB_ADR == ADR_MASK) begin
                mask_reg <= (mask_reg & ~wb_mask[EV_W-1:0]) | (I_WB_DAT[EV_W-1:0] & wb_mask[EV_W-1:0]);
            end
            if (I_WB_ADR == ADR_CTRL) begin
                ctrl_reg[CTRL_VEC12] <= I_WB_SEL[0] ? I_WB_DAT[CTRL_VEC12] : ctrl_reg[CTRL_VEC12];
            end
        end
    end

    // sticky status: an event in the clearing cycle survives
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            status_reg <= '0;
            O_IRQ <= 1'b0;
        end else if (I_CLK_EN) begin
            if (wb_wr && (I_WB_ADR == ADR_STATUS)) begin
                status_reg <= (status_reg & ~(I_WB_DAT[EV_W-1:0] & wb_mask[EV_W-1:0])) | ev_set;
            end else begin
                status_reg <= status_reg | ev_set;
            end
            // one cycle late against the status bits, kept registered for a clean pin
            O_IRQ <= |(status_reg & mask_reg);
        end
    end

    // read mux; unmapped offsets read zero and still ack
    always_comb begin
        wb_rdata = '0;
        case (I_WB_ADR)
            ADR_FLAGS: wb_rdata = flags_reg;
            ADR_STATUS: wb_rdata[EV_W-1:0] = status_reg;
            ADR_MASK: wb_rdata[EV_W-1:0] = mask_reg;
            ADR_MODE: begin
                wb_rdata[MODE_LEGACY] = virtual_machine_flag;
                wb_rdata[MODE_PRIV_LO +: 2] = current_privilege_level;
            end
            ADR_FAULT_EA: wb_rdata = fault_ea_reg;
            ADR_CTRL: wb_rdata[CTRL_VEC12] = ctrl_reg[CTRL_VEC12];
            default: wb_rdata = '0;
        endcase
    end

    // bus answer: ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge I_REF_CLK) begin
        if (I_SYS_RST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= '0;
        end else if (I_CLK_EN) begin
            O_WB_ACK <= wb_req;
            if (wb_req && !I_WB_WE) begin
                O_WB_DAT <= wb_rdata;
            end
        end
    end
endmodule

// File: legacy_mode_address_formation_properties.sv
// Purpose: concurrent checks on the legacy-mode address formation ports
// Assumes: frozen cycles (clock enable low) are not judged; one-cycle registered answers
// Notes: mode is judged from O_DEC_LEGACY, which shows the flag one cycle late
module legacy_mode_address_formation_properties
    import legacy_mode_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_CLK_EN,
    input wire logic I_ACC_REQ,
    input wire logic [31:0] I_ACC_EA,
    input wire logic I_ACC_OPSIZE_PFX,
    input wire logic I_SEG_LOAD,
    input wire logic [SEG_IDX_W-1:0] I_SEG_IDX,
    input wire logic I_PG_CHECK,
    input wire logic I_PG_USER_OK,
    input wire logic I_INT_ENTRY,
    input wire logic I_INT_TO_PL0,
    input wire logic I_INT_RETURN,
    input wire logic I_TASK_LOAD,
    input wire logic I_TASK_FMT32,
    input wire logic O_FAULT,
    input wire logic [7:0] O_FAULT_VEC,
    input wire logic O_FAULT_ERRCODE,
    input wire logic O_LIN_REQ,
    input wire logic O_LIN_USER,
    input wire logic O_LIN_OPSIZE32,
    input wire logic [31:0] O_LIN_ADDR,
    input wire logic O_DESC_FETCH,
    input wire logic O_PG_DENY,
    input wire logic [1:0] O_PRIV_LEVEL,
    input wire logic O_DEC_LEGACY,
    input wire logic O_PUSH_VALID,
    input wire logic [31:0] O_PUSH_DATA
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    // a frozen core holds its outputs, so those cycles are not judged
    default disable iff (I_SYS_RST || !I_CLK_EN);
    // a legacy access either faults on a wide offset or issues a request, never both
    a_legacy_range_fault: assert property ($past(I_ACC_REQ && I_CLK_EN) && O_DEC_LEGACY |->
        O_FAULT == ($past(I_ACC_EA) > EA_MAX) && O_LIN_REQ != O_FAULT) else $error("legacy range check wrong");
    a_protected_no_fault: assert property ($past(I_ACC_REQ && I_CLK_EN) && !O_DEC_LEGACY |->
        O_LIN_REQ && !O_FAULT) else $error("protected access refused");
    // every request carries the privilege it was formed under and the operand-size prefix
    a_lin_user_size: assert property (O_LIN_REQ |-> O_LIN_USER == (O_PRIV_LEVEL == PRIV_USER) &&
        O_LIN_OPSIZE32 == $past(I_ACC_OPSIZE_PFX)) else $error("request privilege or size wrong");
    a_fault_no_errcode: assert property (O_FAULT |-> !O_FAULT_ERRCODE &&
        (O_FAULT_VEC == VEC_GP || O_FAULT_VEC == VEC_STACK)) else $error("fault vector or error code wrong");
    a_legacy_lin_bound: assert property (O_LIN_REQ && O_DEC_LEGACY |-> O_LIN_ADDR <= 32'h0010_ffef)
        else $error("legacy linear address out of range");
    a_legacy_user_level: assert property (O_DEC_LEGACY |-> O_PRIV_LEVEL == PRIV_USER)
        else $error("legacy privilege not 3");
    a_page_deny_user: assert property (I_PG_CHECK && O_PRIV_LEVEL == PRIV_USER |=>
        O_PG_DENY == !$past(I_PG_USER_OK))
        else $error("page deny wrong");
    a_seg_fetch_mode: assert property ($past(I_SEG_LOAD) && $past(I_SEG_IDX) < 3'd6 |->
        O_DESC_FETCH == !O_DEC_LEGACY) else $error("descriptor fetch wrong for mode");
    a_push_before_clear: assert property ($past(I_INT_ENTRY && I_INT_TO_PL0) && O_PUSH_DATA[VMF_BIT] |->
        O_PUSH_VALID && O_DEC_LEGACY ##2 !O_DEC_LEGACY) else $error("flag push or clear order wrong");
    a_return_keeps_flag: assert property (I_INT_RETURN && O_PRIV_LEVEL != PRIV_KERNEL &&
        !I_INT_ENTRY && !I_TASK_LOAD |=> ##1 $stable(O_DEC_LEGACY)) else $error("return changed flag off level 0");
    a_old_task_clears: assert property (I_TASK_LOAD && !I_TASK_FMT32 && !I_INT_ENTRY |=> ##1 !O_DEC_LEGACY)
        else $error("old task format left flag set");
endmodule

bind legacy_mode_address_formation legacy_mode_address_formation_properties legacy_mode_address_formation_properties_inst (.*);

// File: legacy_mode_address_formation_test.sv
// Purpose: self-checking bench for legacy-mode address formation
// Assumes: one-cycle wishbone ack, one-cycle access answer
// Notes: expectations are queued by the driver and popped by the monitor
module legacy_mode_address_formation_test
    import legacy_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, acc = 0, pfx = 0, segld = 0, pgc = 0, pgok = 0;
    logic ient = 0, ipl0 = 0, rtn = 0, tld = 0, t32 = 0, cen = 1, ack, irq, lreq, flt, pushv;
    logic [3:0] bsel = 0; // byte lanes, driven with each bus request
    logic [7:0] adr = 0, fvec;
    logic [31:0] wdat = 0, ea = 0, dbase = 0, iflags = 0, tflags = 0, rdat, laddr, pdat, d, e;
    logic [15:0] sel = 0, sv[6];
    logic [2:0] sidx = 0, aseg = 0;
    logic [1:0] rpl = 0;
    logic [32:0] qa[$]; // queued access answers: fault flag then address or vector
    logic [31:0] qr[$], qp[$]; // queued read data and pushed flags
    int num_errors = 0, n_checks = 0, cycles = 0;

    legacy_mode_address_formation legacy_mode_address_formation_inst (.I_REF_CLK(clk), .I_SYS_RST(rst),
        .I_CLK_EN(cen), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(bsel),
        .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_IRQ(irq), .I_SEG_LOAD(segld), .I_SEG_IDX(sidx),
        .I_SEG_SEL(sel), .I_SEG_DESC_BASE(dbase), .O_DESC_FETCH(), .I_ACC_REQ(acc), .I_ACC_SEG(aseg),
        .I_ACC_EA(ea), .I_ACC_OPSIZE_PFX(pfx), .O_LIN_REQ(lreq), .O_LIN_ADDR(laddr), .O_LIN_USER(),
        .O_LIN_OPSIZE32(), .O_FAULT(flt), .O_FAULT_VEC(fvec), .O_FAULT_ERRCODE(), .I_PG_CHECK(pgc),
        .I_PG_USER_OK(pgok), .O_PG_DENY(), .I_CS_RPL(rpl), .O_PRIV_LEVEL(), .O_DEC_LEGACY(), .I_INT_ENTRY(ient),
        .I_INT_TO_PL0(ipl0), .O_PUSH_VALID(pushv), .O_PUSH_DATA(pdat), .I_INT_RETURN(rtn),
        .I_INT_RETURN_FLAGS(iflags), .I_TASK_LOAD(tld), .I_TASK_FMT32(t32), .I_TASK_FLAGS(tflags));

    always #12.5 clk = ~clk;

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [32:0] got, input logic [32:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // monitor: sampled values at each edge, before the bench's own updates land
    always @(posedge clk) begin
        if (lreq || flt) check({flt, flt ? {24'h0, fvec} : laddr}, qa.pop_front(), "access");
        if (ack && !we) check({1'b0, rdat}, {1'b0, qr.pop_front()}, "read");
        if (pushv) check({1'b0, pdat}, {1'b0, qp.pop_front()}, "push");
        cycles++;
        if (cycles == 4000) begin
            num_errors++;
            summarize();
        end
    end

    // classic single cycle; a read notes its expected data first
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] dv);
        if (!w) qr.push_back(dv);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= dv;
        bsel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1); // only the bench timeout ends a stalled wait
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        bsel <= 4'h0;
        @(posedge clk);
    endtask

    task automatic seg_load(input logic [2:0] s, input logic [15:0] sl, input logic [31:0] db);
        segld <= 1'b1;
        sidx <= s;
        sel <= sl;
        dbase <= db;
        @(posedge clk);
        // the caller lowers the load, so loads may run back to back
    endtask

    // leaves the request up so callers can issue accesses back to back
    task automatic access(input logic [2:0] s, input logic [31:0] ev, input logic [32:0] exp);
        qa.push_back(exp);
        acc <= 1'b1;
        aseg <= s;
        ea <= ev;
        pfx <= 1'($urandom);
        @(posedge clk);
    endtask

    function automatic logic [32:0] lin(input logic [15:0] s, input logic [31:0] ev);
        return {12'h0, {1'b0, s, 4'h0} + {5'h0, ev[15:0]}};
    endfunction

    initial begin
        void'($urandom(53549));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        wb(0, ADR_FLAGS, 32'h0000_0002);
        for (int a = 4; a < 32; a += 4) wb(0, 8'(a), 32'h0); // the other registers and the unmapped places read zero after reset
        $display("done: reset values");
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            e = $urandom;
            seg_load(3'(i), 16'($urandom), d);
            segld <= 1'b0;
            access(3'(i), e, {1'b0, d + e});
            acc <= 1'b0;
        end
        $display("done: protected mode");
        iflags <= 32'h0002_0002;
        rtn <= 1'b1;
        @(posedge clk);
        rtn <= 1'b0;
        repeat (2) @(posedge clk);
        wb(0, ADR_MODE, {29'h0, PRIV_USER, 1'b1});
        for (int i = 0; i < 6; i++) begin
            sv[i] = 16'($urandom);
            seg_load(3'(i), sv[i], $urandom);
        end
        segld <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            e = $urandom & 32'hffff;
            access(3'(i), e, lin(sv[i], e));
        end
        acc <= 1'b0;
        @(posedge clk);
        // a frozen core must hold its state and take the request only once enabled again
        cen <= 1'b0;
        access(3'd0, 32'h0000_0010, lin(sv[0], 32'h0000_0010));
        repeat (2) @(posedge clk);
        cen <= 1'b1;
        @(posedge clk);
        acc <= 1'b0;
        seg_load(3'd5, 16'hffff, 32'h0);
        segld <= 1'b0;
        access(3'd5, 32'h0000_ffff, {1'b0, 32'h0010_ffef});
        access(3'd0, 32'h0001_0000, {1'b1, 24'h0, VEC_GP});
        e = $urandom | 32'h0001_0000;
        access(3'd2, e, {1'b1, 24'h0, VEC_GP});
        acc <= 1'b0;
        wb(1, ADR_CTRL, 32'h1);
        access(3'd3, e, {1'b1, 24'h0, VEC_STACK});
        acc <= 1'b0;
        @(posedge clk);
        wb(0, ADR_FAULT_EA, e);
        wb(0, ADR_STATUS, 32'h5);
        wb(1, ADR_MASK, 32'h1);
        @(posedge clk);
        check({32'h0, irq}, 33'h1, "irq raised");
        wb(1, ADR_MASK, 32'h0);
        @(posedge clk);
        check({32'h0, irq}, 33'h0, "irq masked");
        wb(1, ADR_MASK, 32'h1);
        wb(1, ADR_STATUS, 32'hf);
        @(posedge clk);
        check({32'h0, irq}, 33'h0, "irq cleared");
        $display("done: legacy addressing and faults");
        pgc <= 1'b1;
        @(posedge clk);
        pgok <= 1'b1;
        @(posedge clk);
        pgc <= 1'b0;
        @(posedge clk);
        wb(0, ADR_STATUS, 32'h2);
        wb(1, ADR_STATUS, 32'hf);
        $display("done: page protection");
        rpl <= 2'h1;
        iflags <= 32'h0000_0002;
        rtn <= 1'b1;
        @(posedge clk);
        rtn <= 1'b0;
        repeat (2) @(posedge clk);
        wb(0, ADR_MODE, 32'h7);
        qp.push_back(32'h0002_0002);
        ient <= 1'b1;
        ipl0 <= 1'b1;
        @(posedge clk);
        ient <= 1'b0;
        repeat (3) @(posedge clk);
        wb(0, ADR_MODE, 32'h2);
        tflags <= 32'h0002_0002;
        for (int i = 1; i >= 0; i--) begin
            tld <= 1'b1;
            t32 <= i[0];
            @(posedge clk);
            tld <= 1'b0;
            repeat (2) @(posedge clk);
            wb(0, ADR_MODE, i ? 32'h7 : 32'h2);
        end
        $display("done: mode transitions");
        repeat (4) @(posedge clk);
        check(33'(qa.size() + qr.size() + qp.size()), 33'h0, "leftover");
        summarize();
    end
endmodule

// File: legacy_mode_pkg.sv
// Purpose: shared constants for the legacy-mode address formation block
// Assumes: 32-bit classic wishbone data, byte addresses, 40 MHz core clock
// Notes: register offsets are byte addresses, one aligned word each
package legacy_mode_pkg;
    // flags word layout
    localparam int VMF_BIT = 17;                         // virtual machine flag position
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0002; // bit 1 always reads one
    localparam logic [31:0] FLAGS_FIXED_ONE = 32'h0000_0002;
    // privilege levels
    localparam logic [1:0] PRIV_USER = 2'h3;             // least privileged
    localparam logic [1:0] PRIV_KERNEL = 2'h0;           // most privileged
    // address formation
    localparam int SEG_COUNT = 6;                        // es cs ss ds and the two extra data segments
    localparam int SEG_IDX_W = 3;
    localparam int SEL_SHIFT = 4;                        // selector shifted left four bits
    localparam int BASE_W = 20;                          // legacy base width
    localparam int LIN_W = 21;                           // legacy linear width with carry
    localparam int OFS_W = 16;                           // legacy offset width
    localparam logic [31:0] EA_MAX = 32'h0000_ffff;      // 65,535
    localparam logic [7:0] VEC_STACK = 8'h0c;            // vector 12
    localparam logic [7:0] VEC_GP = 8'h0d;               // vector 13
    // register map
    localparam logic [7:0] ADR_FLAGS = 8'h00;            // flags word, read/write
    localparam logic [7:0] ADR_STATUS = 8'h04;           // sticky events, write one to clear
    localparam logic [7:0] ADR_MASK = 8'h08;             // interrupt enables
    localparam logic [7:0] ADR_MODE = 8'h0c;             // read only: mode and privilege
    localparam logic [7:0] ADR_FAULT_EA = 8'h10;         // read only: last faulting offset
    localparam logic [7:0] ADR_CTRL = 8'h14;             // bit 0 selects fault vector 12
    // status / mask bit positions
    localparam int EV_W = 4;
    localparam int EV_FAULT = 0;
    localparam int EV_PAGE_DENY = 1;
    localparam int EV_LEGACY_ENTER = 2;
    localparam int EV_LEGACY_EXIT = 3;
    localparam int CTRL_VEC12 = 0;
    // mode register layout
    localparam int MODE_LEGACY = 0;
    localparam int MODE_PRIV_LO = 1;
    // interrupt entry sequencing
    typedef enum logic [0:0] {ENT_IDLE, ENT_CLEAR} entry_state_type;
endpackage
